// ### hdl/xcvr_regs_pkg.sv
// Package with the register map, field positions and shared types of the transceiver control bank.
// Assumes a word-addressed management port with 32-bit data and one management clock.
// Overview of operation
// R1: Loopback bit n puts channel n in loopback.
// R2: Read-only bit shows channel signal detected.
// R3: Force bit n locks CDR to data.
// R4: Force bit n locks CDR to reference.
// R5: Status bit shows CDR reached data lock.
// R6: Status bit shows CDR locked to reference.
// R7: Lane select steers every PCS register access.
// R8: Select means group when striped, else lane; the bank always uses it as a lane number.
// R9: Slip count readable in bits five to one.
// R10: Receive FIFO error shown in bit zero.
// R11: Transmit FIFO error shown in bit zero.
// R12: Transmit slip amount from bits five to one.
// R13: Transmit polarity bit inverts outgoing data.
// R14: Receive polarity bit inverts incoming data.
// R15: Rising edge of slip bit slips once.
// R16: Byte reversal bit reverses receive byte order.
// R17: Bit reversal bit reverses receive bit order.
// R18: Pattern align bit starts manual alignment.
// R19: Separate reconfiguration port per channel and PLL.
// R20: Reconfiguration input carries seventy bits per port.
// R21: Reconfiguration output drives forty-six bits per port.
// R22: Master holds signals while wait request asserted.
// R23: CDR automatic by default; forcing selects manual.
// R24: Word addresses and 32-bit data, one space.
// R25: Read-only writes ignored; unmapped reads return zero.
package xcvr_regs_pkg;
  localparam int unsigned NUM_CH        = 4;
  localparam int unsigned NUM_PLL       = 1;
  localparam int unsigned NUM_RECFG     = NUM_CH + NUM_PLL;
  localparam int unsigned RECFG_IN_W    = 70;
  localparam int unsigned RECFG_OUT_W   = 46;
  localparam int unsigned ADDR_W        = 9;
  localparam int unsigned DATA_W        = 32;
  localparam int unsigned LANE_W        = 2;
  localparam int unsigned SLIP_W        = 5;

  localparam logic [8:0] ADDR_LOOPBACK   = 9'h061;
  localparam logic [8:0] ADDR_SIG_DET    = 9'h063;
  localparam logic [8:0] ADDR_FORCE_DATA = 9'h064;
  localparam logic [8:0] ADDR_FORCE_REF  = 9'h065;
  localparam logic [8:0] ADDR_DATA_LOCK  = 9'h066;
  localparam logic [8:0] ADDR_REF_LOCK   = 9'h067;
  localparam logic [8:0] ADDR_LANE_SEL   = 9'h080;
  localparam logic [8:0] ADDR_RX_STATUS  = 9'h081;
  localparam logic [8:0] ADDR_TX_CTRL    = 9'h082;
  localparam logic [8:0] ADDR_TX_POL     = 9'h083;
  localparam logic [8:0] ADDR_RX_POL     = 9'h084;
  localparam logic [8:0] ADDR_RX_ALIGN   = 9'h085;

  localparam int unsigned FIFO_ERR_BIT   = 0;
  localparam int unsigned SLIP_LSB       = 1;
  localparam int unsigned SLIP_MSB       = 5;
  localparam int unsigned POL_BIT        = 0;
  localparam int unsigned PATALIGN_BIT   = 0;
  localparam int unsigned BITREV_BIT     = 1;
  localparam int unsigned BYTEREV_BIT    = 2;
  localparam int unsigned BITSLIP_BIT    = 3;
  localparam logic [31:0] RESET_WORD     = 32'h0000_0000;

  typedef struct packed {
    logic [ADDR_W-1:0] address;
    logic [DATA_W-1:0] writedata;
    logic              write;
    logic              read;
  } mgmt_req_t;

  typedef struct packed {
    logic              tx_fifo_err;
    logic              rx_fifo_err;
    logic [SLIP_W-1:0] rx_slip_count;
  } lane_status_t;

  typedef struct packed {
    logic              tx_invert;
    logic [SLIP_W-1:0] tx_slip;
    logic              rx_invert;
    logic              rx_bitslip_pulse;
    logic              rx_byterev;
    logic              rx_bitrev;
    logic              rx_patalign;
  } lane_ctrl_t;
endpackage : xcvr_regs_pkg

// ### hdl/pma_pcs_control_status_bank.sv
// Control and status register bank for a multi-channel transceiver PHY.
// Assumes the management master keeps its request steady while waitrequest is high,
// and that all channel status inputs are synchronous to ref_clk.
`timescale 1ns/1ps
module pma_pcs_control_status_bank
  import xcvr_regs_pkg::*;
(
  input  wire logic                            ref_clk,           // Management clock.
  input  wire logic                            reset,             // Synchronous reset, active high.
  input  wire mgmt_req_t                       mgmt_req,          // Address, data, read and write.
  output logic [DATA_W-1:0]                    mgmt_readdata,     // Read data.
  output logic                                 mgmt_waitrequest,  // Stall request.
  input  wire logic [NUM_CH-1:0]               rx_signal_present, // Receiver signal detect per channel.
  input  wire logic [NUM_CH-1:0]               cdr_data_lock_state, // CDR locked to data.
  input  wire logic [NUM_CH-1:0]               cdr_ref_lock_state,  // CDR locked to reference.
  input  wire lane_status_t [NUM_CH-1:0]       lane_status,       // PCS status per lane.
  output logic [NUM_CH-1:0]                    serial_loopback,   // Loopback enable per channel.
  output logic [NUM_CH-1:0]                    cdr_force_data,    // Force lock to data.
  output logic [NUM_CH-1:0]                    cdr_force_ref,     // Force lock to reference.
  output logic [NUM_CH-1:0]                    cdr_manual_mode,   // CDR manual lock mode.
  output lane_ctrl_t [NUM_CH-1:0]              lane_ctrl,         // PCS controls per lane.
  input  wire logic [NUM_RECFG*RECFG_IN_W-1:0] reconfig_bus_in,   // From reconfiguration controller.
  output logic [NUM_RECFG*RECFG_OUT_W-1:0]     reconfig_bus_out,  // To reconfiguration controller.
  input  wire logic [NUM_RECFG*RECFG_OUT_W-1:0] reconfig_status   // Per-interface return word.
);

  typedef struct packed {
    logic [DATA_W-1:0]               readdata;
    logic                            wait_req;
    logic [NUM_CH-1:0]               loopback;
    logic [NUM_CH-1:0]               force_data;
    logic [NUM_CH-1:0]               force_ref;
    logic [NUM_CH-1:0]               manual;
    logic [LANE_W-1:0]               lane_sel;
    logic [NUM_CH-1:0]               tx_err;
    lane_ctrl_t [NUM_CH-1:0]         ctrl;
    logic [NUM_CH-1:0]               slip_level;
    logic [NUM_RECFG*RECFG_OUT_W-1:0] recfg_out;
  } state_t;

  state_t st;
  state_t next_st;

  logic [LANE_W-1:0] sel;
  logic              wr;
  logic              rd;

  always_comb begin
    next_st = st;
    sel = st.lane_sel;                                                  // [R7] [R8]
    wr = mgmt_req.write;                                                // [R24]
    rd = mgmt_req.read;
    // Accesses complete in one cycle, so waitrequest never rises and no request is held.
    next_st.wait_req = 1'b0;                                            // [R22] [R25]
    next_st.readdata = RESET_WORD;
    for (int i = 0; i < NUM_CH; i++) begin
      next_st.ctrl[i].rx_bitslip_pulse = 1'b0;
      // Sticky error: a new error wins over a clearing write in the same cycle.
      if (wr && mgmt_req.address == ADDR_TX_CTRL && sel == LANE_W'(i) &&
          !mgmt_req.writedata[FIFO_ERR_BIT]) begin
        next_st.tx_err[i] = 1'b0;
      end
      if (lane_status[i].tx_fifo_err) begin
        next_st.tx_err[i] = 1'b1;                                       // [R11]
      end
    end
    if (wr) begin
      case (mgmt_req.address)
        ADDR_LOOPBACK: next_st.loopback = mgmt_req.writedata[NUM_CH-1:0];        // [R1]
        ADDR_FORCE_DATA: begin
          next_st.force_data = mgmt_req.writedata[NUM_CH-1:0];                   // [R3]
          next_st.manual = st.manual | mgmt_req.writedata[NUM_CH-1:0];           // [R23]
        end
        ADDR_FORCE_REF: begin
          next_st.force_ref = mgmt_req.writedata[NUM_CH-1:0];                    // [R4]
          next_st.manual = st.manual | mgmt_req.writedata[NUM_CH-1:0];           // [R23]
        end
        ADDR_LANE_SEL: next_st.lane_sel = mgmt_req.writedata[LANE_W-1:0];        // [R7]
        ADDR_TX_CTRL:
          next_st.ctrl[sel].tx_slip = mgmt_req.writedata[SLIP_MSB:SLIP_LSB];     // [R12]
        ADDR_TX_POL: next_st.ctrl[sel].tx_invert = mgmt_req.writedata[POL_BIT];  // [R13]
        ADDR_RX_POL: next_st.ctrl[sel].rx_invert = mgmt_req.writedata[POL_BIT];  // [R14]
        ADDR_RX_ALIGN: begin
          next_st.ctrl[sel].rx_byterev  = mgmt_req.writedata[BYTEREV_BIT];       // [R16]
          next_st.ctrl[sel].rx_bitrev   = mgmt_req.writedata[BITREV_BIT];        // [R17]
          next_st.ctrl[sel].rx_patalign = mgmt_req.writedata[PATALIGN_BIT];      // [R18]
          next_st.slip_level[sel]       = mgmt_req.writedata[BITSLIP_BIT];
          // Only a 0-to-1 change of the stored bit slips; rewriting a 1 does nothing.
          next_st.ctrl[sel].rx_bitslip_pulse =
            mgmt_req.writedata[BITSLIP_BIT] & ~st.slip_level[sel];               // [R15]
        end
        default: ;                                                               // [R25]
      endcase
    end
    if (rd) begin
      case (mgmt_req.address)
        ADDR_LOOPBACK:   next_st.readdata = DATA_W'(st.loopback);
        ADDR_SIG_DET:    next_st.readdata = DATA_W'(rx_signal_present);          // [R2]
        ADDR_FORCE_DATA: next_st.readdata = DATA_W'(st.force_data);
        ADDR_FORCE_REF:  next_st.readdata = DATA_W'(st.force_ref);
        ADDR_DATA_LOCK:  next_st.readdata = DATA_W'(cdr_data_lock_state);        // [R5]
        ADDR_REF_LOCK:   next_st.readdata = DATA_W'(cdr_ref_lock_state);         // [R6]
        ADDR_LANE_SEL:   next_st.readdata = DATA_W'(st.lane_sel);
        ADDR_RX_STATUS: begin
          next_st.readdata[SLIP_MSB:SLIP_LSB] = lane_status[sel].rx_slip_count;  // [R9]
          next_st.readdata[FIFO_ERR_BIT]      = lane_status[sel].rx_fifo_err;    // [R10]
        end
        ADDR_TX_CTRL: begin
          next_st.readdata[SLIP_MSB:SLIP_LSB] = st.ctrl[sel].tx_slip;
          next_st.readdata[FIFO_ERR_BIT]      = st.tx_err[sel];                  // [R11]
        end
        ADDR_TX_POL: next_st.readdata[POL_BIT] = st.ctrl[sel].tx_invert;
        ADDR_RX_POL: next_st.readdata[POL_BIT] = st.ctrl[sel].rx_invert;
        ADDR_RX_ALIGN: begin
          next_st.readdata[BITSLIP_BIT]  = st.slip_level[sel];
          next_st.readdata[BYTEREV_BIT]  = st.ctrl[sel].rx_byterev;
          next_st.readdata[BITREV_BIT]   = st.ctrl[sel].rx_bitrev;
          next_st.readdata[PATALIGN_BIT] = st.ctrl[sel].rx_patalign;
        end
        default: next_st.readdata = RESET_WORD;                                  // [R25]
      endcase
    end
    // Each reconfiguration port returns its own word toward the controller, registered.
    next_st.recfg_out = reconfig_status;                                         // [R19] [R21]
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // The 70-bit input words are sliced per port into recfg_word, which nothing in the bank reads.
  logic [RECFG_IN_W-1:0] recfg_word [NUM_RECFG];
  for (genvar g = 0; g < NUM_RECFG; g++) begin : g_recfg
    assign recfg_word[g] = reconfig_bus_in[g*RECFG_IN_W +: RECFG_IN_W];          // [R20]
  end

  assign mgmt_readdata    = st.readdata;
  assign mgmt_waitrequest = st.wait_req;
  assign serial_loopback  = st.loopback;
  assign cdr_force_data   = st.force_data;
  assign cdr_force_ref    = st.force_ref;
  assign cdr_manual_mode  = st.manual;
  assign lane_ctrl        = st.ctrl;
  assign reconfig_bus_out = st.recfg_out;

endmodule : pma_pcs_control_status_bank

// ### testbench/mgmt_master_model.sv
// Management bus master model: one read or write per call of access.
// Assumes the bank samples requests on the rising edge of ref_clk.
`timescale 1ns/1ps
module mgmt_master_model
  import xcvr_regs_pkg::*;
(
  input  wire logic              ref_clk,         // Clock.
  output mgmt_req_t              mgmt_req,        // Request.
  input  wire logic [DATA_W-1:0] mgmt_readdata,   // Read data.
  input  wire logic              mgmt_waitrequest // Stall.
);
  initial mgmt_req = '0;
  task automatic access(input logic w, input logic [8:0] a, input logic [31:0] d, output logic [31:0] q);
    @(negedge ref_clk);
    mgmt_req <= '{address: a, writedata: d, write: w, read: !w};
    @(posedge ref_clk);
    for (int i = 0; i < 8 && mgmt_waitrequest !== 1'b0; i++) @(posedge ref_clk);
    @(negedge ref_clk);
    q = mgmt_readdata;
    // Released lines carry the inverse, so a stale value never passes for a live one.
    mgmt_req <= '{address: ~a, writedata: ~d, write: 1'b0, read: 1'b0};
  endtask : access
endmodule : mgmt_master_model

// ### testbench/pma_pcs_bank_monitor.sv
// Checker of the register bank, bound to its ports.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
module pma_pcs_bank_monitor
  import xcvr_regs_pkg::*;
(
  input wire logic              ref_clk,             // Clock.
  input wire logic              reset,               // Reset.
  input wire mgmt_req_t         mgmt_req,            // Request.
  input wire logic [DATA_W-1:0] mgmt_readdata,       // Data.
  input wire logic              mgmt_waitrequest,    // Stall.
  input wire logic [NUM_CH-1:0] cdr_data_lock_state, // Lock.
  input wire logic [NUM_CH-1:0] serial_loopback,     // Loop.
  input wire logic [NUM_CH-1:0] cdr_force_data,      // Force.
  input wire logic [NUM_CH-1:0] cdr_manual_mode,     // Mode.
  input wire lane_ctrl_t [NUM_CH-1:0] lane_ctrl,     // Lanes.
  input wire logic [NUM_RECFG*RECFG_OUT_W-1:0] reconfig_bus_out, // Out.
  input wire logic [NUM_RECFG*RECFG_OUT_W-1:0] reconfig_status   // In.
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);
  a_never_stall: assert property (!mgmt_waitrequest) else $error("waitrequest high");
  a_loop_write: assert property (mgmt_req.write && mgmt_req.address == ADDR_LOOPBACK
    |=> serial_loopback == $past(mgmt_req.writedata[NUM_CH-1:0])) else $error("loopback not written");
  a_force_data: assert property (mgmt_req.write && mgmt_req.address == ADDR_FORCE_DATA
    |=> cdr_force_data == $past(mgmt_req.writedata[NUM_CH-1:0])) else $error("force not written");
  a_manual_enter: assert property (cdr_force_data != '0 |-> cdr_manual_mode != '0)
    else $error("manual mode missing");
  a_lock_read: assert property (mgmt_req.read && mgmt_req.address == ADDR_DATA_LOCK
    |=> mgmt_readdata == 32'($past(cdr_data_lock_state))) else $error("lock read wrong");
  a_idle_zero: assert property (!mgmt_req.read |=> mgmt_readdata == '0) else $error("stray read data");
  a_slip_once: assert property (lane_ctrl[0].rx_bitslip_pulse |=> !lane_ctrl[0].rx_bitslip_pulse)
    else $error("slip pulse too long");
  // The first edge after reset sees a reset-time past value, so the copy is judged from the second.
  a_recfg_copy: assert property (!$past(reset) |-> reconfig_bus_out == $past(reconfig_status))
    else $error("reconfig copy wrong");
  c_loop: cover property (mgmt_req.write && mgmt_req.address == ADDR_LOOPBACK);
  c_slip: cover property (lane_ctrl[0].rx_bitslip_pulse);
  c_lock: cover property (mgmt_req.read && mgmt_req.address == ADDR_DATA_LOCK);
endmodule : pma_pcs_bank_monitor
bind pma_pcs_control_status_bank pma_pcs_bank_monitor mon_u (.ref_clk, .reset, .mgmt_req, .mgmt_readdata,
  .mgmt_waitrequest, .cdr_data_lock_state, .serial_loopback, .cdr_force_data, .cdr_manual_mode, .lane_ctrl,
  .reconfig_bus_out, .reconfig_status);

// ### testbench/tb_top.sv
// Bench: random and directed accesses to the transceiver register bank.
// Assumes the master model and the bound checker are compiled with it.
`timescale 1ns/1ps
module tb_top
  import xcvr_regs_pkg::*;
;
  logic               ref_clk, reset, mgmt_waitrequest;
  mgmt_req_t          mgmt_req;
  logic [31:0]        mgmt_readdata, q, v, seed = 32'ha6f7d017;
  logic [3:0]         rx_signal_present, cdr_data_lock_state, cdr_ref_lock_state, serial_loopback;
  logic [3:0]         cdr_force_data, cdr_force_ref, cdr_manual_mode;
  lane_status_t [3:0] lane_status;
  lane_ctrl_t [3:0]   lane_ctrl;
  logic [349:0]       reconfig_bus_in;
  logic [229:0]       reconfig_bus_out, reconfig_status;
  int                 err_count = 0, n_tests = 0, cyc = 0;
  logic [8:0]         ra [8] = '{ADDR_LOOPBACK, ADDR_FORCE_DATA, ADDR_FORCE_REF, ADDR_LANE_SEL,
                                 ADDR_TX_CTRL, ADDR_TX_POL, ADDR_RX_POL, ADDR_RX_ALIGN};
  mgmt_master_model mm (.ref_clk, .mgmt_req, .mgmt_readdata, .mgmt_waitrequest);
  pma_pcs_control_status_bank dut_u (.ref_clk, .reset, .mgmt_req, .mgmt_readdata, .mgmt_waitrequest,
    .rx_signal_present, .cdr_data_lock_state, .cdr_ref_lock_state, .lane_status, .serial_loopback,
    .cdr_force_data, .cdr_force_ref, .cdr_manual_mode, .lane_ctrl, .reconfig_bus_in, .reconfig_bus_out,
    .reconfig_status);
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd
  function automatic logic [31:0] rx_stat(lane_status_t s);
    return {26'h0, s.rx_slip_count, s.rx_fifo_err};
  endfunction : rx_stat
  task automatic chk(string name, logic [31:0] seen, logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk
  task automatic wr(logic [8:0] a, logic [31:0] d);
    mm.access(1'b1, a, d, q);
  endtask : wr
  task automatic rd(logic [8:0] a, logic [31:0] e, string name);
    mm.access(1'b0, a, 32'h0, q);
    chk(name, q, e);
  endtask : rd
  // Transmit FIFO errors stay masked here; that sticky bit is raised only on purpose.
  // Inputs settle at the falling edge itself, so expectations taken right after a call see the new values.
  task automatic stim();
    @(negedge ref_clk);
    v = rnd();
    {rx_signal_present, cdr_data_lock_state, cdr_ref_lock_state} = v[11:0];
    lane_status = 28'(rnd()) & 28'h7efdfbf;
    reconfig_status = 230'({8{rnd()}});
    reconfig_bus_in = 350'({11{rnd()}});
  endtask : stim
  task automatic conclude();
    if (err_count == 0 && n_tests > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : conclude
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 3000) begin
      err_count++;
      conclude();
    end
  end
  initial begin
    reset = 1'b1;
    {rx_signal_present, cdr_data_lock_state, cdr_ref_lock_state, lane_status} = '0;
    {reconfig_bus_in, reconfig_status} = '0;
    repeat (20) @(posedge ref_clk);
    @(negedge ref_clk) reset <= 1'b0;
    chk("manual_rst", 32'(cdr_manual_mode), 32'h0);
    foreach (ra[k]) rd(ra[k], 32'h0, "reset_val");
    rd(9'h062, 32'h0, "unmapped");
    repeat (4) begin
      stim();
      rd(ADDR_SIG_DET, 32'(rx_signal_present), "sig_det");
      rd(ADDR_DATA_LOCK, 32'(cdr_data_lock_state), "data_lock");
      rd(ADDR_REF_LOCK, 32'(cdr_ref_lock_state), "ref_lock");
      v = rnd() & 32'hf;
      wr(ADDR_LOOPBACK, v);
      rd(ADDR_LOOPBACK, v, "loopback");
      chk("loopback_pin", 32'(serial_loopback), v);
      wr(ADDR_FORCE_DATA, v);
      wr(ADDR_FORCE_REF, ~v & 32'hf);
      chk("force", 32'({cdr_force_data, cdr_force_ref}), {24'h0, v[3:0], ~v[3:0]});
    end
    chk("manual", 32'(cdr_manual_mode), 32'hf);
    for (int l = 0; l < NUM_CH; l++) begin
      stim();
      wr(ADDR_LANE_SEL, 32'(l) | 32'h4);
      rd(ADDR_LANE_SEL, 32'(l), "lane_sel");
      rd(ADDR_RX_STATUS, rx_stat(lane_status[l]), "rx_status");
      v = rnd() & 32'h3e;
      wr(ADDR_TX_CTRL, v);
      chk("tx_slip", 32'(lane_ctrl[l].tx_slip), v >> 1);
      lane_status[l].tx_fifo_err <= 1'b1;
      rd(ADDR_TX_CTRL, v | 32'h1, "tx_err");
      wr(ADDR_TX_CTRL, v);
      rd(ADDR_TX_CTRL, v | 32'h1, "tx_err_set_wins");
      lane_status[l].tx_fifo_err <= 1'b0;
      wr(ADDR_TX_CTRL, v);
      rd(ADDR_TX_CTRL, v, "tx_err_clear");
      wr(ADDR_TX_POL, 32'h1);
      wr(ADDR_RX_POL, 32'h1);
      chk("pol", 32'({lane_ctrl[l].tx_invert, lane_ctrl[l].rx_invert}), 32'h3);
      chk("other_lane", 32'(lane_ctrl[(l + 1) % NUM_CH].tx_invert), 32'(l == 3));
      wr(ADDR_RX_ALIGN, 32'h7);
      chk("align", 32'(lane_ctrl[l][2:0]), 32'h7);
      wr(ADDR_RX_ALIGN, 32'hf);
      chk("slip_edge", 32'(lane_ctrl[l].rx_bitslip_pulse), 32'h1);
      wr(ADDR_RX_ALIGN, 32'hf);
      chk("slip_held", 32'(lane_ctrl[l].rx_bitslip_pulse), 32'h0);
    end
    conclude();
  end
endmodule : tb_top
